// File: core/gpc_pkg.sv
// Overview of operation
// - Eight pins, each configured independently
// - Bit x of three registers sets pin x
// - Reset clears registers: input, pull-up, no interrupt
// - Input pin: data read returns pin level
// - Option 0: data 0 pull-up, 1 plain
// - Option 1, data 0: pull-up with interrupt
// - Option 1, data 1: analog input to converter
// - Output pin: latch drives pin, read returns latch
// - Output option 0 open-drain, 1 push-pull
// - Data 0 pulls low; open-drain 1 floats
// - Per-port trigger: falling, rising or low level
// - Interrupt needs interrupt mode and global enable
// - Sleep keeps pins; enabled interrupt wakes device
package gpc_pkg;
    localparam int unsigned NPINS          = 8;
    localparam logic [31:0] OFF_LATCH      = 32'h0000_0000;
    localparam logic [31:0] OFF_DIR        = 32'h0000_0004;
    localparam logic [31:0] OFF_OPT        = 32'h0000_0008;
    localparam logic [31:0] OFF_IRQ_OPT    = 32'h0000_000c;
    localparam logic [31:0] OFF_IRQ_STAT   = 32'h0000_0010;
    localparam logic [31:0] OFF_IRQ_MASK   = 32'h0000_0014;
    localparam logic [7:0]  RST_PORT       = 8'h00;
    localparam logic [1:0]  RST_TRIG       = 2'h0;
    localparam logic        RST_GEN        = 1'b0;
    localparam int unsigned POS_TRIG       = 0;
    localparam int unsigned POS_GEN        = 4;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;

    typedef enum logic [1:0] {
        GPC_TRIG_FALL,
        GPC_TRIG_RISE,
        GPC_TRIG_LOW
    } gpc_trig_t;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] pull_up;
        logic [7:0] analog_sel;
    } gpc_pad_t;

    typedef struct packed {
        logic [7:0] latch_reg;
        logic [7:0] dir_reg;
        logic [7:0] opt_reg;
        logic [1:0] trig_reg;
        logic       gen_reg;
        logic       stat_reg;
        logic       mask_reg;
        logic [7:0] sync1_reg;
        logic [7:0] sync2_reg;
        logic [7:0] prev_reg;
        logic       dphase_reg;
        logic       dwrite_reg;
        logic [4:0] daddr_reg;
        logic [31:0] rdata_reg;
    } gpc_state_t;
endpackage : gpc_pkg

// File: core/gpc_port.sv
module gpc_port (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    input  wire logic [7:0]          pin_i,
    output gpc_pkg::gpc_pad_t        pad_o,
    output logic                     ext_irq_o,
    output logic                     wake_o,
    output logic                     irq_o
);
    gpc_pkg::gpc_state_t s_reg;
    gpc_pkg::gpc_state_t s_next;
    logic [7:0] irq_en;
    logic [7:0] hit;
    logic       event_any;
    logic       wr_stat_clear;
    logic       in_map;

    // Interrupt-mode pins: input, option 1, data 0
    function automatic logic [7:0] irq_pins(input logic [7:0] d, input logic [7:0] o, input logic [7:0] l);
        irq_pins = ~d & o & ~l;
    endfunction

    always_comb begin
        irq_en = irq_pins(s_reg.dir_reg, s_reg.opt_reg, s_reg.latch_reg);
        unique case (gpc_pkg::gpc_trig_t'(s_reg.trig_reg))
            gpc_pkg::GPC_TRIG_RISE: hit = irq_en & s_reg.sync2_reg & ~s_reg.prev_reg;
            gpc_pkg::GPC_TRIG_LOW:  hit = irq_en & ~s_reg.sync2_reg;
            default:                hit = irq_en & ~s_reg.sync2_reg & s_reg.prev_reg;
        endcase
        event_any = (|hit) && s_reg.gen_reg;
    end

    always_comb begin
        s_next = s_reg;
        wr_stat_clear = 1'b0;
        // Only the low 32 bytes decode; higher addresses must not alias the port registers
        in_map = (haddr_i[31:5] == 27'h0000000);
        // Input synchronizer; only the second stage is looked at
        s_next.sync1_reg = pin_i;
        s_next.sync2_reg = s_reg.sync1_reg;
        s_next.prev_reg  = s_reg.sync2_reg;
        s_next.dphase_reg = 1'b0;
        if (s_reg.dphase_reg && s_reg.dwrite_reg) begin
            unique case ({27'h0000000, s_reg.daddr_reg})
                gpc_pkg::OFF_LATCH:    s_next.latch_reg = hwdata_i[7:0];
                gpc_pkg::OFF_DIR:      s_next.dir_reg   = hwdata_i[7:0];
                gpc_pkg::OFF_OPT:      s_next.opt_reg   = hwdata_i[7:0];
                gpc_pkg::OFF_IRQ_OPT: begin
                    s_next.trig_reg = hwdata_i[gpc_pkg::POS_TRIG +: 2];
                    s_next.gen_reg  = hwdata_i[gpc_pkg::POS_GEN];
                end
                gpc_pkg::OFF_IRQ_STAT: wr_stat_clear = hwdata_i[0];
                gpc_pkg::OFF_IRQ_MASK: s_next.mask_reg = hwdata_i[0];
                default: ;
            endcase
        end
        // A new event beats a simultaneous clear
        if (wr_stat_clear) begin
            s_next.stat_reg = 1'b0;
        end
        if (event_any) begin
            s_next.stat_reg = 1'b1;
        end
        if (hsel_i && hready_i && htrans_i[1]) begin
            s_next.dphase_reg = 1'b1;
            s_next.dwrite_reg = hwrite_i && in_map;
            s_next.daddr_reg  = haddr_i[4:0];
            s_next.rdata_reg  = 32'h0000_0000;
            if (!hwrite_i && in_map) begin
                unique case ({27'h0000000, haddr_i[4:2], 2'b00})
                    // Input bits show the pin, output bits the latch
                    gpc_pkg::OFF_LATCH: s_next.rdata_reg[7:0] =
                        (s_reg.dir_reg & s_reg.latch_reg) | (~s_reg.dir_reg & s_reg.sync2_reg);
                    gpc_pkg::OFF_DIR:      s_next.rdata_reg[7:0] = s_reg.dir_reg;
                    gpc_pkg::OFF_OPT:      s_next.rdata_reg[7:0] = s_reg.opt_reg;
                    gpc_pkg::OFF_IRQ_OPT: begin
                        s_next.rdata_reg[gpc_pkg::POS_TRIG +: 2] = s_reg.trig_reg;
                        s_next.rdata_reg[gpc_pkg::POS_GEN]       = s_reg.gen_reg;
                    end
                    gpc_pkg::OFF_IRQ_STAT: s_next.rdata_reg[0] = s_reg.stat_reg;
                    gpc_pkg::OFF_IRQ_MASK: s_next.rdata_reg[0] = s_reg.mask_reg;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_reg            <= '0;
            s_reg.latch_reg  <= gpc_pkg::RST_PORT;
            s_reg.dir_reg    <= gpc_pkg::RST_PORT;
            s_reg.opt_reg    <= gpc_pkg::RST_PORT;
            s_reg.trig_reg   <= gpc_pkg::RST_TRIG;
            s_reg.gen_reg    <= gpc_pkg::RST_GEN;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pad control is a pure decode of the three port registers per bit
    always_comb begin
        for (int i = 0; i < gpc_pkg::NPINS; i++) begin
            // Drive enabled for low in any output mode, for high only in push-pull
            pad_o.out[i] = s_reg.latch_reg[i];
            pad_o.oe[i]  = s_reg.dir_reg[i] & (~s_reg.latch_reg[i] | s_reg.opt_reg[i]);
            pad_o.pull_up[i] = ~s_reg.dir_reg[i] & ~s_reg.latch_reg[i];
            pad_o.analog_sel[i] = ~s_reg.dir_reg[i] & s_reg.opt_reg[i] & s_reg.latch_reg[i];
        end
    end

    // Pins are untouched by sleep; the wake request is the gated event itself
    assign ext_irq_o   = event_any;
    assign wake_o      = event_any;
    assign irq_o       = s_reg.stat_reg & s_reg.mask_reg;
    assign hrdata_o    = s_reg.rdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
endmodule // gpc_port

// File: testbench/gpc_port_checker.sv
module gpc_port_checker (
    input wire logic              ref_clk_i,
    input wire logic              rst_i,
    input wire logic              hreadyout_o,
    input wire logic              hresp_o,
    input wire gpc_pkg::gpc_pad_t pad_o,
    input wire logic              ext_irq_o,
    input wire logic              wake_o,
    input wire logic              irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ready_high_a: assert property (hreadyout_o)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp_o)
        else $error("error response");
    wake_tracks_a: assert property (wake_o == ext_irq_o)
        else $error("wake differs from irq");
    drive_not_analog_a: assert property ((pad_o.oe & pad_o.analog_sel) == 8'h00)
        else $error("driven analog pad");
    drive_not_pull_a: assert property ((pad_o.oe & pad_o.pull_up) == 8'h00)
        else $error("driven pad pulled");
    analog_not_pull_a: assert property ((pad_o.analog_sel & pad_o.pull_up) == 8'h00)
        else $error("analog pad pulled");
    reset_pads_a: assert property ($fell(rst_i) |-> pad_o == {8'h00, 8'h00, 8'hff, 8'h00})
        else $error("pads not reset");
    reset_irq_a: assert property ($fell(rst_i) |-> !irq_o && !ext_irq_o ##1 !irq_o)
        else $error("irq after reset");
endmodule // gpc_port_checker
bind gpc_port gpc_port_checker gpc_port_checker_inst (.ref_clk_i, .rst_i, .hreadyout_o, .hresp_o,
    .pad_o, .ext_irq_o, .wake_o, .irq_o);

// File: testbench/gpc_pin_model.sv
module gpc_pin_model (
    input  wire logic              ref_clk_i,
    input  wire gpc_pkg::gpc_pad_t pad_i,
    input  wire logic [7:0]        ext_i,
    input  wire logic [7:0]        ext_en_i,
    output logic      [7:0]        pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_reg = 8'h55;
    // A floating pad keeps toggling so a read of it never matches by luck
    always_ff @(posedge ref_clk_i) float_reg <= ~float_reg;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_i.oe[i]) pin_o[i] = pad_i.out[i];
            else if (ext_en_i[i]) pin_o[i] = ext_i[i];
            else if (pad_i.pull_up[i]) pin_o[i] = 1'b1;
            else pin_o[i] = float_reg[i];
        end
    end
endmodule // gpc_pin_model

// File: testbench/test_gpc_port.sv
module test_gpc_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [1:0]        htrans_i = 2'h0;
    logic [31:0]       haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic [7:0]        pin_i, ext = 8'h00, ext_en = 8'h00;
    logic              hreadyout_o, hresp_o, ext_irq_o, wake_o, irq_o;
    gpc_pkg::gpc_pad_t pad_o;
    int                bad_count = 0, n_checks = 0;
    gpc_port gpc_port_inst (.ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(gpc_pkg::HSIZE_WORD), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .pin_i, .pad_o, .ext_irq_o, .wake_o, .irq_o);
    gpc_pin_model gpc_pin_model_inst (.ref_clk_i, .pad_i(pad_o), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pin_i));
    initial forever #50 ref_clk_i = ~ref_clk_i;
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= gpc_pkg::HTRANS_NONSEQ;
        hwrite_i <= w;
        wait_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_rdy();
        rd = hrdata_o;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [7:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rd[7:0]);
    endtask
    // Pin 0 idles high with the trigger off, so only the event under test can set status
    task automatic trig_case(input logic [7:0] cfg, input logic msk, exp_stat, exp_irq);
        bus(1'b1, gpc_pkg::OFF_IRQ_OPT, 32'h0);
        ext <= 8'h01;
        repeat (4) @(posedge ref_clk_i);
        bus(1'b1, gpc_pkg::OFF_IRQ_STAT, 32'h1);
        bus(1'b1, gpc_pkg::OFF_IRQ_MASK, {31'h0, msk});
        bus(1'b1, gpc_pkg::OFF_IRQ_OPT, {24'h0, cfg});
        ext <= 8'h00;
        repeat (5) @(posedge ref_clk_i);
        chk("irq", {7'h0, exp_irq}, {7'h0, irq_o});
        rchk(gpc_pkg::OFF_IRQ_STAT, {7'h0, exp_stat}, "stat");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rchk(gpc_pkg::OFF_DIR, 8'h00, "dir");
        rchk(gpc_pkg::OFF_OPT, 8'h00, "opt");
        rchk(gpc_pkg::OFF_LATCH, 8'hff, "pins");
        bus(1'b1, gpc_pkg::OFF_DIR, 32'hff);
        bus(1'b1, gpc_pkg::OFF_OPT, 32'h0f);
        bus(1'b1, gpc_pkg::OFF_LATCH, 32'ha5);
        rchk(gpc_pkg::OFF_LATCH, 8'ha5, "latch");
        chk("oe", 8'h5f, pad_o.oe);
        chk("out", 8'h05, pad_o.out & pad_o.oe);
        // Latch and option change while still outputs, so at most one pad ever turns analog
        bus(1'b1, gpc_pkg::OFF_LATCH, 32'h3c);
        bus(1'b1, gpc_pkg::OFF_OPT, 32'h10);
        bus(1'b1, gpc_pkg::OFF_DIR, 32'h0);
        ext_en <= 8'h0f;
        // Pad decode only shows the last write once its edge has updated the registers
        @(posedge ref_clk_i);
        chk("pull", 8'hc3, pad_o.pull_up);
        chk("analog", 8'h10, pad_o.analog_sel);
        repeat (3) @(posedge ref_clk_i);
        bus(1'b0, gpc_pkg::OFF_LATCH, 32'h0);
        chk("pins", 8'hc0, rd[7:0] & 8'hcf);
        bus(1'b1, gpc_pkg::OFF_OPT, 32'h1);
        bus(1'b1, gpc_pkg::OFF_LATCH, 32'h0);
        ext_en <= 8'h01;
        trig_case(8'h10, 1'b1, 1'b1, 1'b1);
        trig_case(8'h11, 1'b1, 1'b0, 1'b0);
        trig_case(8'h12, 1'b1, 1'b1, 1'b1);
        chk("ext_irq", 8'h01, {7'h0, ext_irq_o});
        chk("wake", 8'h01, {7'h0, wake_o});
        trig_case(8'h00, 1'b1, 1'b0, 1'b0);
        chk("ext_irq", 8'h00, {7'h0, ext_irq_o});
        chk("wake", 8'h00, {7'h0, wake_o});
        trig_case(8'h10, 1'b0, 1'b1, 1'b0);
        rchk(gpc_pkg::OFF_IRQ_OPT, 8'h10, "irq_opt");
        rchk(gpc_pkg::OFF_IRQ_MASK, 8'h00, "mask");
        rchk(32'h40, 8'h00, "unmapped");
        print_verdict();
    end
endmodule // test_gpc_port
